// ### design/mmd_cfg.svh
// Purpose: Address map, limits and default values for the memory map decoder
// Assumes: 24-bit byte addresses, upper byte is the segment number
// Notes: Definitions only
`ifndef MMD_CFG_SVH
`define MMD_CFG_SVH

// ****************
// Segment numbers
// ****************
`define MMD_SEG_SYS 8'h00
`define MMD_SEG_EXT_HI 8'h1f
`define MMD_SEG_PERIPH 8'h20
`define MMD_SEG_IO_HI 8'h3f
`define MMD_SEG_EXTM_HI 8'hbf
`define MMD_SEG_NVM0 8'hc0
`define MMD_SEG_NVM1 8'hc4
`define MMD_SEG_NVM_HI 8'hc4
`define MMD_SEG_PROGRAM_SRAM 8'he0
`define MMD_SEG_EMU 8'he8

// ****************
// Offsets inside a segment, sizes and counts
// ****************
`define MMD_SYS_EXT_END 16'h8000
`define MMD_SYS_RSV_END 16'ha000
`define MMD_SYS_DATA_SRAM_END 16'he000
`define MMD_SYS_XREG_END 16'hf000
`define MMD_SYS_EXTENDED_REG_AREA_END 16'hf200
`define MMD_SYS_RSV2_END 16'hf600
`define MMD_SYS_DUAL_PORT_RAM_END 16'hfe00
`define MMD_SYS_DUAL_PORT_RAM_BIT 16'hfd00
`define MMD_PER_RSV1_LO 16'h5800
`define MMD_PER_RSV1_HI 16'h8000
`define MMD_PER_RSV2_LO 16'hbc00
`define MMD_NVM_INT_LO 16'hf000
`define MMD_RAM16K_END 16'h4000
`define MMD_IMB_LO 16'hff00
`define MMD_GPR_BANK_BYTES 24'h000020
`define MMD_PROGRAM_SRAM_MAX 16384
`define MMD_NVM_CLUSTERS 8
`define MMD_NVM_SECT_PER_CLUSTER 4

`endif

// ### design/mmd_decoder.sv
// Purpose: Region decode and access checks for a 16-Mbyte segmented space
// Assumes: One access request per cycle, inputs synchronous to sys_clk
// Notes: All results but nvm_unlocked_reg, which follows a cycle later, are registered at the edge that takes the request
`include "mmd_cfg.svh"
`timescale 1ns/1ps

module mmd_decoder #(
  parameter bit HAS_EXT_BUS = 1'b1,
  parameter int PROGRAM_SRAM_BYTES = `MMD_PROGRAM_SRAM_MAX,
  parameter int NVM_CLUSTERS = `MMD_NVM_CLUSTERS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic acc_valid,
  input wire logic acc_fetch,
  input wire logic acc_write,
  input wire logic acc_word,
  input wire logic acc_bit,
  input wire logic [23:0] acc_addr,
  input wire logic [13:0] program_sram_wp_size,
  input wire logic [NVM_CLUSTERS-1:0] nvm_prot_cluster,
  input wire logic nvm_read_prot,
  input wire logic [23:0] context_pointer,
  input wire logic gpr_valid,
  input wire logic gpr_byte,
  input wire logic [3:0] gpr_idx,
  input wire logic stk_acc,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] stack_overflow_limit,
  input wire logic [15:0] stack_underflow_limit,
  input wire logic par_en,
  input wire logic ecc_en,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic [5:0] rd_check,
  input wire logic pw_valid,
  input wire logic [15:0] pw_word,
  input wire logic pw_relock,
  output mmd_pkg::mmd_region_t region_sel_reg,
  output logic program_mgmt_unit_reg,
  output logic data_mgmt_unit_reg,
  output logic sysbus_xfer_reg,
  output logic strict_order_reg,
  output logic acc_error_reg,
  output logic wr_blocked_reg,
  output logic bit_ok_reg,
  output logic [19:0] nvm_line_reg,
  output logic nvm_module_reg,
  output logic [11:0] nvm_sector_reg,
  output logic [23:0] gpr_addr_reg,
  output logic gpr_error_reg,
  output logic stk_over_reg,
  output logic stk_under_reg,
  output logic rd_valid_reg,
  output logic [15:0] rd_data_reg,
  output logic rd_err_reg,
  output logic rd_fixed_reg,
  output logic nvm_unlocked_reg
);

  // ****************
  // Elaboration checks
  // ****************
  generate
    if (PROGRAM_SRAM_BYTES < 1 || PROGRAM_SRAM_BYTES > `MMD_PROGRAM_SRAM_MAX) begin : g_bad_program_sram
      $error("PROGRAM_SRAM_BYTES must lie in 1..16384");
    end
    if (NVM_CLUSTERS < 1 || NVM_CLUSTERS > `MMD_NVM_CLUSTERS) begin : g_bad_clu
      $error("NVM_CLUSTERS must lie in 1..8");
    end
  endgenerate

  // ****************
  // Region decode
  // ****************

  // Maps one byte address to its region; reserved holes follow has_ext
  function automatic mmd_pkg::mmd_region_t decode_region(input logic [23:0] a, input logic has_ext);
    logic [7:0] seg;
    logic [15:0] ofs;
    mmd_pkg::mmd_region_t rsv;
    seg = a[23:16];
    ofs = a[15:0];
    rsv = has_ext ? mmd_pkg::MMD_RG_EXT_BUS : mmd_pkg::MMD_RG_ERROR;
    decode_region = rsv;
    if (seg == `MMD_SEG_SYS) begin
      if (ofs < `MMD_SYS_EXT_END) begin
        decode_region = mmd_pkg::MMD_RG_EXT_BUS;
      end else if (ofs < `MMD_SYS_RSV_END) begin
        decode_region = rsv;
      end else if (ofs < `MMD_SYS_DATA_SRAM_END) begin
        decode_region = mmd_pkg::MMD_RG_DATA_SRAM;
      end else if (ofs < `MMD_SYS_XREG_END) begin
        decode_region = mmd_pkg::MMD_RG_XREG;
      end else if (ofs < `MMD_SYS_EXTENDED_REG_AREA_END) begin
        decode_region = mmd_pkg::MMD_RG_EXTENDED_REG_AREA;
      end else if (ofs < `MMD_SYS_RSV2_END) begin
        decode_region = rsv;
      end else if (ofs < `MMD_SYS_DUAL_PORT_RAM_END) begin
        decode_region = mmd_pkg::MMD_RG_DUAL_PORT_RAM;
      end else begin
        decode_region = mmd_pkg::MMD_RG_SPECIAL_REG_AREA;
      end
    end else if (seg <= `MMD_SEG_EXT_HI) begin
      decode_region = mmd_pkg::MMD_RG_EXT_BUS;
    end else if (seg == `MMD_SEG_PERIPH) begin
      if ((ofs >= `MMD_PER_RSV1_LO && ofs < `MMD_PER_RSV1_HI) || ofs >= `MMD_PER_RSV2_LO) begin
        decode_region = rsv;
      end else begin
        decode_region = mmd_pkg::MMD_RG_SYSBUS_PERIPH;
      end
    end else if (seg <= `MMD_SEG_IO_HI) begin
      decode_region = mmd_pkg::MMD_RG_EXT_IO;
    end else if (seg <= `MMD_SEG_EXTM_HI) begin
      decode_region = mmd_pkg::MMD_RG_EXT_BUS;
    end else if (seg == `MMD_SEG_NVM0 && ofs >= `MMD_NVM_INT_LO) begin
      decode_region = mmd_pkg::MMD_RG_ERROR;
    end else if (seg <= `MMD_SEG_NVM_HI) begin
      decode_region = mmd_pkg::MMD_RG_NVM;
    end else if (seg == `MMD_SEG_PROGRAM_SRAM && ofs < `MMD_RAM16K_END) begin
      decode_region = mmd_pkg::MMD_RG_PROGRAM_SRAM;
    end else if (seg == `MMD_SEG_EMU && ofs < `MMD_RAM16K_END) begin
      decode_region = mmd_pkg::MMD_RG_EMU_PROGRAM_SRAM;
    end else if (seg == 8'hff && ofs >= `MMD_IMB_LO) begin
      decode_region = mmd_pkg::MMD_RG_IMB;
    end
  endfunction

  // Region of the current access, full 24-bit decode
  wire mmd_pkg::mmd_region_t region = decode_region(acc_addr, HAS_EXT_BUS);
  wire logic rg_nvm = (region == mmd_pkg::MMD_RG_NVM);
  wire logic rg_program_sram = (region == mmd_pkg::MMD_RG_PROGRAM_SRAM);
  wire logic rg_dual_port_ram = (region == mmd_pkg::MMD_RG_DUAL_PORT_RAM);
  wire logic rg_regs = (region == mmd_pkg::MMD_RG_SPECIAL_REG_AREA) ||
                       (region == mmd_pkg::MMD_RG_EXTENDED_REG_AREA);
  wire logic program_side = rg_nvm || rg_program_sram || (region == mmd_pkg::MMD_RG_EMU_PROGRAM_SRAM);

  // ****************
  // Register bank and bit addressing
  // ****************

  // Word n at cp+2n, byte half n at cp+n
  wire logic [23:0] gpr_ofs = gpr_byte ? {20'h00000, gpr_idx} : {19'h00000, gpr_idx, 1'b0};
  wire logic [23:0] gpr_addr = context_pointer + gpr_ofs;
  wire logic gpr_bad = 1'b0;
  wire logic [23:0] bank_end = context_pointer + `MMD_GPR_BANK_BYTES;
  wire logic in_bank = (acc_addr >= context_pointer) && (acc_addr < bank_end);
  wire logic dual_port_ram_bit = rg_dual_port_ram && (acc_addr[15:0] >= `MMD_SYS_DUAL_PORT_RAM_BIT);
  wire logic bit_ok = rg_regs || dual_port_ram_bit || (rg_dual_port_ram && in_bank);

  // Word-wide register areas take only aligned word and bit accesses
  wire logic regs_bad = rg_regs && !acc_bit && (!acc_word || acc_addr[0]);
  wire logic align_bad = acc_word && acc_addr[0];

  // ****************
  // Protection checks
  // ****************

  // Program SRAM protected section starts at the bottom of the array
  wire logic [13:0] program_sram_ofs = acc_addr[13:0];
  wire logic program_sram_beyond = {18'h00000, program_sram_ofs} >= PROGRAM_SRAM_BYTES;
  wire logic program_sram_wp = rg_program_sram && acc_write && (program_sram_ofs < program_sram_wp_size);

  // Sector index within the whole space; sectors grouped into clusters
  wire logic [11:0] sector = acc_addr[23:12];
  wire logic [7:0] cluster_idx = 8'(sector[5:0] / `MMD_NVM_SECT_PER_CLUSTER);
  wire logic cluster_ok = cluster_idx < NVM_CLUSTERS;
  wire logic cluster_prot = cluster_ok ? nvm_prot_cluster[cluster_idx[2:0]] : 1'b1;
  wire logic nvm_wp = rg_nvm && acc_write && cluster_prot;
  wire logic nvm_unlocked;
  wire logic nvm_rp = rg_nvm && !acc_write && !acc_fetch && nvm_read_prot && !nvm_unlocked;

  wire logic write_blocked = program_sram_wp || nvm_wp;
  wire logic fetch_bad = acc_fetch && (acc_write || !(program_side || region == mmd_pkg::MMD_RG_EXT_BUS));
  wire logic any_error = (region == mmd_pkg::MMD_RG_ERROR) || regs_bad || align_bad || write_blocked ||
                         nvm_rp || (acc_bit && !bit_ok) || fetch_bad || (rg_program_sram && program_sram_beyond);

  // ****************
  // Stack limit comparison
  // ****************

  // Stack grows downward: below the overflow limit or above underflow
  wire logic stk_over = stk_acc && (stack_ptr < stack_overflow_limit);
  wire logic stk_under = stk_acc && (stack_ptr > stack_underflow_limit);

  // ****************
  // Access result registers
  // ****************

  // Region and routing outputs, held when no request is taken
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      region_sel_reg <= mmd_pkg::MMD_RG_EXT_BUS;
      program_mgmt_unit_reg <= 1'b0;
      data_mgmt_unit_reg <= 1'b0;
      sysbus_xfer_reg <= 1'b0;
      strict_order_reg <= 1'b0;
    end else if (acc_valid) begin
      region_sel_reg <= any_error ? mmd_pkg::MMD_RG_ERROR : region;
      program_mgmt_unit_reg <= acc_fetch;
      data_mgmt_unit_reg <= !acc_fetch;
      sysbus_xfer_reg <= !acc_fetch && (program_side || region == mmd_pkg::MMD_RG_EXT_BUS ||
                         region == mmd_pkg::MMD_RG_EXT_IO || region == mmd_pkg::MMD_RG_SYSBUS_PERIPH);
      strict_order_reg <= (region == mmd_pkg::MMD_RG_EXT_IO);
    end
  end

  // Error, protection and bit-access flags; one-cycle pulses per request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc_error_reg <= 1'b0;
      wr_blocked_reg <= 1'b0;
      bit_ok_reg <= 1'b0;
    end else begin
      acc_error_reg <= acc_valid && any_error;
      wr_blocked_reg <= acc_valid && write_blocked;
      bit_ok_reg <= acc_valid && acc_bit && bit_ok;
    end
  end

  // Non-volatile line, module and sector of the access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvm_line_reg <= 20'h00000;
      nvm_module_reg <= 1'b0;
      nvm_sector_reg <= 12'h000;
    end else if (acc_valid && rg_nvm) begin
      nvm_line_reg <= acc_addr[23:4];
      nvm_module_reg <= (acc_addr[23:16] == `MMD_SEG_NVM1);
      nvm_sector_reg <= sector;
    end
  end

  // Register bank address, byte halves for all sixteen; error flag never set
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gpr_addr_reg <= 24'h000000;
      gpr_error_reg <= 1'b0;
    end else begin
      if (gpr_valid) begin
        gpr_addr_reg <= gpr_addr;
      end
      gpr_error_reg <= gpr_valid && gpr_bad;
    end
  end

  // Stack flags, one pulse per offending stack access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stk_over_reg <= 1'b0;
      stk_under_reg <= 1'b0;
    end else begin
      stk_over_reg <= stk_over;
      stk_under_reg <= stk_under;
    end
  end

  // Unlock state mirrored to a port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvm_unlocked_reg <= 1'b0;
    end else begin
      nvm_unlocked_reg <= nvm_unlocked;
    end
  end

  // ****************
  // Sub-blocks
  // ****************

  // Read-data checking, parity or ECC
  mmd_ecc_chk #(
    .DATA_W(16)
  ) u_ecc (
    .sys_clk(sys_clk),
    .reset(reset),
    .par_en(par_en),
    .ecc_en(ecc_en),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .rd_check(rd_check),
    .out_valid_reg(rd_valid_reg),
    .out_data_reg(rd_data_reg),
    .out_err_reg(rd_err_reg),
    .out_fixed_reg(rd_fixed_reg)
  );

  // Password sequence for non-volatile read protection
  mmd_pwd_lock #(
    .PW_LEN(2)
  ) u_pwd (
    .sys_clk(sys_clk),
    .reset(reset),
    .pw_valid(pw_valid),
    .pw_word(pw_word),
    .pw_relock(pw_relock),
    .unlocked_reg(nvm_unlocked)
  );

endmodule

// ### design/mmd_ecc_chk.sv
// Purpose: Parity check or single-error correction of one memory word
// Assumes: check[4:0] hold Hamming bits, check[5] holds even parity
// Notes: Result is registered one cycle after rd_valid
`timescale 1ns/1ps
module mmd_ecc_chk #(
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic par_en,
  input wire logic ecc_en,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [5:0] rd_check,
  output logic out_valid_reg,
  output logic [DATA_W-1:0] out_data_reg,
  output logic out_err_reg,
  output logic out_fixed_reg
);
  localparam int CODE_W = DATA_W + 5;

  generate
    if (DATA_W != 16) begin : g_bad
      $error("mmd_ecc_chk serves 16-bit words only");
    end
  endgenerate

  logic [DATA_W-1:0] fixed_data;
  logic [4:0] syndrome;
  logic par_bad;

  // Syndrome over the Hamming codeword, then flip the bit it names
  always_comb begin
    int d;
    int k;
    logic [CODE_W:1] code;
    d = 0;
    k = 0;
    code = '0;
    syndrome = 5'h00;
    fixed_data = '0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) == 0) begin
        code[p] = rd_check[k];
        k = k + 1;
      end else begin
        code[p] = rd_data[d];
        d = d + 1;
      end
      if (code[p]) begin
        syndrome = syndrome ^ p[4:0];
      end
    end
    d = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        fixed_data[d] = code[p] ^ (syndrome == p[4:0]);
        d = d + 1;
      end
    end
  end

  assign par_bad = par_en && !ecc_en && (^{rd_data, rd_check[5]});

  // Corrupt parity words are withheld, corrected words pass
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
      out_err_reg <= 1'b0;
      out_fixed_reg <= 1'b0;
    end else begin
      out_valid_reg <= rd_valid && !par_bad;
      out_data_reg <= !rd_valid || par_bad ? '0 : (ecc_en ? fixed_data : rd_data);
      out_err_reg <= rd_valid && par_bad;
      out_fixed_reg <= rd_valid && ecc_en && (syndrome != 5'h00);
    end
  end
endmodule

// ### design/mmd_pkg.sv
// Purpose: Types shared by the memory map decoder files
// Assumes: Used as mmd_pkg::name, never imported
// Notes: Region codes are one-hot
package mmd_pkg;

  // One-hot region select, exactly one bit per access
  typedef enum logic [12:0] {
    MMD_RG_EXT_BUS = 13'h0001,
    MMD_RG_EXT_IO = 13'h0002,
    MMD_RG_DATA_SRAM = 13'h0004,
    MMD_RG_XREG = 13'h0008,
    MMD_RG_EXTENDED_REG_AREA = 13'h0010,
    MMD_RG_DUAL_PORT_RAM = 13'h0020,
    MMD_RG_SPECIAL_REG_AREA = 13'h0040,
    MMD_RG_SYSBUS_PERIPH = 13'h0080,
    MMD_RG_NVM = 13'h0100,
    MMD_RG_PROGRAM_SRAM = 13'h0200,
    MMD_RG_EMU_PROGRAM_SRAM = 13'h0400,
    MMD_RG_IMB = 13'h0800,
    MMD_RG_ERROR = 13'h1000
  } mmd_region_t;

endpackage

// ### design/mmd_pwd_lock.sv
// Purpose: Password sequence that lifts non-volatile read protection
// Assumes: Words arrive one per pw_valid pulse
// Notes: Password values are arbitrary defaults
`timescale 1ns/1ps
module mmd_pwd_lock #(
  parameter int PW_LEN = 2,
  parameter logic [15:0] PW_WORD0 = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] PW_WORD1 = 16'ha5a5 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pw_valid,
  input wire logic [15:0] pw_word,
  input wire logic pw_relock,
  output logic unlocked_reg
);
  generate
    if (PW_LEN != 2) begin : g_bad
      $error("mmd_pwd_lock serves a two-word sequence only");
    end
  endgenerate

  logic step_reg;
  wire logic [15:0] expect_word = step_reg ? PW_WORD1 : PW_WORD0;
  wire logic word_ok = pw_valid && (pw_word == expect_word);

  // A wrong word restarts the sequence; relock wins over completion
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      step_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else begin
      if (pw_valid) begin
        step_reg <= word_ok && !step_reg;
      end
      if (pw_relock) begin
        unlocked_reg <= 1'b0;
      end else if (word_ok && step_reg) begin
        unlocked_reg <= 1'b1;
      end
    end
  end
endmodule

// ### tb/memory_map_decoder_tb.sv
// Purpose: Self-checking bench of the memory map decoder
// Assumes: Inputs change on the falling edge, results read a cycle later
// Notes: Expected values come from the address map constants
`timescale 1ns/1ps
module memory_map_decoder_tb;
  logic sys_clk, reset, acc_valid, acc_fetch, acc_write, acc_word, acc_bit;
  logic [23:0] acc_addr, context_pointer, gpr_addr_reg;
  logic [13:0] program_sram_wp_size;
  logic [7:0] nvm_prot_cluster;
  logic nvm_read_prot, gpr_valid, gpr_byte, stk_acc, par_en, ecc_en, rd_valid, pw_valid, pw_relock;
  logic [3:0] gpr_idx;
  logic [15:0] stack_ptr, stack_overflow_limit, stack_underflow_limit, rd_data, pw_word, rd_data_reg;
  logic [5:0] rd_check;
  mmd_pkg::mmd_region_t region_sel_reg;
  logic program_mgmt_unit_reg, data_mgmt_unit_reg, strict_order_reg, acc_error_reg, wr_blocked_reg, bit_ok_reg;
  logic [19:0] nvm_line_reg;
  logic [11:0] nvm_sector_reg;
  logic nvm_module_reg, stk_over_reg, stk_under_reg, rd_valid_reg, rd_err_reg, rd_fixed_reg, nvm_unlocked_reg;
  logic sysbus_xfer_reg, gpr_error_reg;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  mmd_cpu_model mmd_cpu_model_inst (.sys_clk, .acc_valid, .acc_fetch, .acc_write, .acc_word, .acc_bit, .acc_addr);
  mmd_decoder mmd_decoder_inst (.sys_clk, .reset, .acc_valid, .acc_fetch, .acc_write, .acc_word, .acc_bit, .acc_addr,
    .program_sram_wp_size, .nvm_prot_cluster, .nvm_read_prot, .context_pointer, .gpr_valid, .gpr_byte, .gpr_idx, .stk_acc,
    .stack_ptr, .stack_overflow_limit, .stack_underflow_limit, .par_en, .ecc_en, .rd_valid, .rd_data, .rd_check,
    .pw_valid, .pw_word, .pw_relock, .region_sel_reg, .program_mgmt_unit_reg, .data_mgmt_unit_reg,
    .sysbus_xfer_reg, .strict_order_reg, .acc_error_reg, .wr_blocked_reg, .bit_ok_reg, .nvm_line_reg,
    .nvm_module_reg, .nvm_sector_reg, .gpr_addr_reg, .gpr_error_reg, .stk_over_reg, .stk_under_reg,
    .rd_valid_reg, .rd_data_reg, .rd_err_reg, .rd_fixed_reg, .nvm_unlocked_reg);

  // ****************
  // Clock, timeout and helpers
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Hang guard, the whole run needs well under 400 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One access, then its three one-cycle flags
  task automatic acc_flags(input logic [3:0] fwb, input logic [23:0] a, input logic [2:0] exp);
    mmd_cpu_model_inst.issue(fwb[3], fwb[2], fwb[1], fwb[0], a);
    check({acc_error_reg, wr_blocked_reg, bit_ok_reg}, exp);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_map();
    logic [23:0] a [15];
    mmd_pkg::mmd_region_t r [15];
    a = '{24'h000000, 24'h008000, 24'h00a000, 24'h00e000, 24'h00f000, 24'h00f600, 24'h00fe00, 24'h200000,
      24'h210000, 24'h400000, 24'hc00000, 24'hc0f000, 24'he00200, 24'he04000, 24'hffff00};
    r = '{mmd_pkg::MMD_RG_EXT_BUS, mmd_pkg::MMD_RG_EXT_BUS, mmd_pkg::MMD_RG_DATA_SRAM, mmd_pkg::MMD_RG_XREG,
      mmd_pkg::MMD_RG_EXTENDED_REG_AREA, mmd_pkg::MMD_RG_DUAL_PORT_RAM, mmd_pkg::MMD_RG_SPECIAL_REG_AREA,
      mmd_pkg::MMD_RG_SYSBUS_PERIPH, mmd_pkg::MMD_RG_EXT_IO, mmd_pkg::MMD_RG_EXT_BUS, mmd_pkg::MMD_RG_NVM,
      mmd_pkg::MMD_RG_ERROR, mmd_pkg::MMD_RG_PROGRAM_SRAM, mmd_pkg::MMD_RG_EXT_BUS, mmd_pkg::MMD_RG_IMB};
    for (int i = 0; i < 15; i++) begin
      mmd_cpu_model_inst.issue(1'b0, 1'b0, 1'b1, 1'b0, a[i]);
      check(24'(region_sel_reg), 24'(r[i]));
      check(strict_order_reg, r[i] == mmd_pkg::MMD_RG_EXT_IO);
      check(acc_error_reg, r[i] == mmd_pkg::MMD_RG_ERROR);
    end
    $display("t_map done");
  endtask
  task automatic t_err();
    acc_flags(4'h2, 24'h00a001, 3'h4);
    acc_flags(4'h0, 24'h00fe01, 3'h4);
    acc_flags(4'h1, 24'h00fd00, 3'h1);
    acc_flags(4'h1, 24'h00a000, 3'h4);
    acc_flags(4'h4, 24'he00010, 3'h6);
    acc_flags(4'h4, 24'he00200, 3'h0);
    acc_flags(4'ha, 24'h00a000, 3'h4);
    acc_flags(4'h6, 24'hc41230, 3'h6);
    acc_flags(4'h6, 24'hc45000, 3'h0);
    $display("t_err done");
  endtask
  task automatic t_nvm();
    nvm_read_prot = 1'b1;
    acc_flags(4'h2, 24'hc41230, 3'h4);
    mmd_cpu_model_inst.issue(1'b1, 1'b0, 1'b1, 1'b0, 24'hc00000);
    check({program_mgmt_unit_reg, data_mgmt_unit_reg, sysbus_xfer_reg}, 3'h4);
    // Software supplies the unlock words on consecutive cycles
    {pw_valid, pw_word} = {1'b1, 16'h5a5a};
    @(negedge sys_clk) pw_word = 16'ha5a5;
    @(negedge sys_clk) pw_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(nvm_unlocked_reg, 1'b1);
    mmd_cpu_model_inst.issue(1'b0, 1'b0, 1'b1, 1'b0, 24'hc41230);
    check(24'(region_sel_reg), 24'(mmd_pkg::MMD_RG_NVM));
    check({nvm_line_reg, nvm_module_reg}, {20'hc4123, 1'b1});
    check(nvm_sector_reg, 12'hc41);
    check(sysbus_xfer_reg, 1'b1);
    pw_relock = 1'b1;
    @(negedge sys_clk) pw_relock = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(nvm_unlocked_reg, 1'b0);
    $display("t_nvm done");
  endtask
  task automatic t_gpr_stk();
    {gpr_valid, gpr_byte, gpr_idx} = {1'b1, 1'b0, 4'h3};
    @(negedge sys_clk) {gpr_byte, gpr_idx} = {1'b1, 4'h5};
    check(gpr_addr_reg, 24'h00fc06);
    @(negedge sys_clk) gpr_valid = 1'b0;
    check(gpr_addr_reg, 24'h00fc05);
    check(gpr_error_reg, 1'b0);
    {stk_acc, stack_ptr} = {1'b1, 16'hf900};
    @(negedge sys_clk) stack_ptr = 16'hfd00;
    check({stk_over_reg, stk_under_reg}, 2'b10);
    @(negedge sys_clk) stack_ptr = 16'hfb00;
    check({stk_over_reg, stk_under_reg}, 2'b01);
    @(negedge sys_clk) stk_acc = 1'b0;
    check({stk_over_reg, stk_under_reg}, 2'b00);
    $display("t_gpr_stk done");
  endtask
  // Raw word into the checker, result one cycle later
  task automatic rd(input logic p, e, input logic [15:0] d, input logic [5:0] c);
    {rd_valid, par_en, ecc_en, rd_data, rd_check} = {1'b1, p, e, d, c};
    @(negedge sys_clk) rd_valid = 1'b0;
  endtask
  task automatic t_rd();
    rd(1'b0, 1'b1, 16'h0001, 6'h00);
    check({rd_fixed_reg, rd_data_reg}, {1'b1, 16'h0000});
    rd(1'b0, 1'b1, 16'h0000, 6'h01);
    check({rd_fixed_reg, rd_data_reg}, {1'b1, 16'h0000});
    rd(1'b1, 1'b0, 16'h0001, 6'h00);
    check({rd_err_reg, rd_valid_reg, rd_data_reg}, {2'b10, 16'h0000});
    rd(1'b1, 1'b0, 16'h0003, 6'h00);
    check({rd_err_reg, rd_valid_reg, rd_data_reg}, {2'b01, 16'h0003});
    $display("t_rd done");
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    {reset, nvm_read_prot, gpr_valid, gpr_byte, stk_acc, par_en, ecc_en, rd_valid, pw_valid, pw_relock} = 10'h200;
    {program_sram_wp_size, nvm_prot_cluster, context_pointer, gpr_idx} = {14'h0100, 8'h01, 24'h00fc00, 4'h0};
    {stack_ptr, stack_overflow_limit, stack_underflow_limit} = {16'hfb00, 16'hfa00, 16'hfc00};
    {rd_data, rd_check, pw_word} = {16'h0000, 6'h00, 16'h0000};
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    check(24'(region_sel_reg), 24'(mmd_pkg::MMD_RG_EXT_BUS));
    check({acc_error_reg, nvm_unlocked_reg, gpr_addr_reg}, 26'h0);
    t_map();
    t_err();
    t_nvm();
    t_gpr_stk();
    t_rd();
    summarize();
  end
endmodule

// ### tb/mmd_cpu_model.sv
// Purpose: CPU side model that issues access requests to the decoder
// Assumes: Requests change on the falling edge of sys_clk
// Notes: Idle address lines carry the inverse of the last address
`timescale 1ns/1ps
module mmd_cpu_model (
  input wire logic sys_clk,
  output logic acc_valid,
  output logic acc_fetch,
  output logic acc_write,
  output logic acc_word,
  output logic acc_bit,
  output logic [23:0] acc_addr
);
  // ****************
  // Request driver
  // ****************
  // Idle state at time zero
  initial begin
    {acc_valid, acc_fetch, acc_write, acc_word, acc_bit} = 5'h00;
    acc_addr = 24'h000000;
  end

  // One request held across one taking edge, only addresses asked
  task automatic issue(input logic f, input logic w, input logic wd, input logic b, input logic [23:0] a);
    @(negedge sys_clk);
    {acc_valid, acc_fetch, acc_write, acc_word, acc_bit} = {1'b1, f, w, wd, b};
    acc_addr = a;
    @(negedge sys_clk);
    acc_valid = 1'b0;
    acc_addr = ~a; // Released lines show no stale address
  endtask
endmodule

// ### tb/mmd_decoder_asserts.sv
// Purpose: Port level checks of the memory map decoder
// Assumes: One clock domain, synchronous active high reset
// Notes: Password words match the decoder defaults
`timescale 1ns/1ps
module mmd_decoder_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic acc_valid,
  input wire logic acc_fetch,
  input wire logic acc_write,
  input wire logic acc_word,
  input wire logic acc_bit,
  input wire logic [23:0] acc_addr,
  input wire logic [13:0] program_sram_wp_size,
  input wire logic stk_acc,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] stack_overflow_limit,
  input wire logic [15:0] stack_underflow_limit,
  input wire logic pw_valid,
  input wire logic [15:0] pw_word,
  input wire logic pw_relock,
  input wire mmd_pkg::mmd_region_t region_sel_reg,
  input wire logic data_mgmt_unit_reg,
  input wire logic strict_order_reg,
  input wire logic acc_error_reg,
  input wire logic wr_blocked_reg,
  input wire logic stk_over_reg,
  input wire logic stk_under_reg,
  input wire logic nvm_unlocked_reg
);
  // ****************
  // Sequences and properties
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Plain data access, aligned, no bit mode
  sequence plain_acc;
    acc_valid && !acc_fetch && !acc_bit && !(acc_word && acc_addr[0]);
  endsequence
  sequence pw_pair;
    pw_valid && pw_word == 16'h5a5a && !pw_relock ##1 pw_valid && pw_word == 16'ha5a5 && !pw_relock;
  endsequence

  one_hot_sel_a: assert property ($onehot(region_sel_reg)) else $error("region select not one-hot");
  dual_port_ram_route_a: assert property (plain_acc ##0 (acc_addr >= 24'h00f600 && acc_addr < 24'h00fe00)
    |=> region_sel_reg == mmd_pkg::MMD_RG_DUAL_PORT_RAM && data_mgmt_unit_reg) else $error("dual-port RAM misrouted");
  param_sector_a: assert property (acc_valid && acc_addr[23:12] == 12'hc0f
    |=> acc_error_reg && region_sel_reg == mmd_pkg::MMD_RG_ERROR) else $error("internal sector reachable");
  io_strict_a: assert property (plain_acc ##0 (acc_addr >= 24'h210000 && acc_addr <= 24'h3fffff)
    |=> strict_order_reg && region_sel_reg == mmd_pkg::MMD_RG_EXT_IO) else $error("IO access not ordered");
  odd_word_a: assert property (acc_valid && acc_word && acc_addr[0] |=> acc_error_reg) else $error("odd word taken");
  program_sram_block_a: assert property (plain_acc ##0 (acc_write && !acc_word && acc_addr[23:16] == 8'he0
    && acc_addr[15:0] < {2'h0, program_sram_wp_size}) |=> wr_blocked_reg && acc_error_reg) else $error("protected write passed");
  stk_over_a: assert property (1'b1 |=> stk_over_reg == $past(stk_acc && stack_ptr < stack_overflow_limit))
    else $error("overflow flag wrong");
  stk_under_a: assert property (1'b1 |=> stk_under_reg == $past(stk_acc && stack_ptr > stack_underflow_limit))
    else $error("underflow flag wrong");
  pw_unlock_a: assert property (pw_pair ##1 !pw_relock |=> nvm_unlocked_reg) else $error("password did not unlock");
  relock_a: assert property (pw_relock |-> ##2 !nvm_unlocked_reg) else $error("relock ignored");
endmodule

bind mmd_decoder mmd_decoder_asserts mmd_decoder_asserts_inst (.sys_clk, .reset, .acc_valid, .acc_fetch, .acc_write,
  .acc_word, .acc_bit, .acc_addr, .program_sram_wp_size, .stk_acc, .stack_ptr, .stack_overflow_limit, .stack_underflow_limit,
  .pw_valid, .pw_word, .pw_relock, .region_sel_reg, .data_mgmt_unit_reg, .strict_order_reg, .acc_error_reg,
  .wr_blocked_reg, .stk_over_reg, .stk_under_reg, .nvm_unlocked_reg);
